// File: hdl/gw_pkg.sv
// Shared constants, types and image helpers of the cyclic I/O gateway
package gw_pkg;

  localparam int CLK_HZ          = 25_000_000;
  localparam int DATA_RATE_BPS   = 19_200;
  localparam int CHAR_BITS       = 11;
  localparam int CHAR_DIV_CYC    = CLK_HZ * CHAR_BITS / DATA_RATE_BPS;
  localparam int COMM_TIMEOUT_MS = 1000;
  localparam int TIMEOUT_CYC     = (CLK_HZ / 1000) * COMM_TIMEOUT_MS;
  localparam int RSP_TIMEOUT_MS  = 100;
  localparam int RSP_WAIT_CYC    = (CLK_HZ / 1000) * RSP_TIMEOUT_MS;

  localparam int MAX_LINKS = 4;
  localparam int LINKS_W   = MAX_LINKS * 64;
  localparam int MAX_BYTES = 2 + 4 + MAX_LINKS * 8;
  localparam int IMG_W     = MAX_BYTES * 8;
  localparam int IDX_W     = 6;

  localparam logic [7:0] ADDR_MIN = 8'h01;

  localparam int CW_STOP   = 0;
  localparam int CW_START  = 1;
  localparam int CW_CLEAR  = 3;
  localparam int CW_CLSTOP = 8;
  localparam int CW_COAST  = 9;

  localparam logic [8:0] ERR_INC   = 9'h008;
  localparam logic [8:0] ERR_DEC   = 9'h001;
  localparam logic [8:0] ERR_LIMIT = 9'h100;

  typedef enum logic [1:0] {
    FA_CONFIG = 2'b00,
    FA_HOLD   = 2'b01,
    FA_ZERO   = 2'b10
  } fault_action_t;

  typedef struct packed {
    logic [15:0]        w0;
    logic [31:0]        w1;
    logic [LINKS_W-1:0] lk;
  } image_t;

  // Parity bit that makes the count of ones even, or odd when odd is set
  function automatic logic par_bit(input logic [7:0] d, input logic odd);
    return (^d) ^ odd;
  endfunction

  // Image length in bytes: word, setpoint word, then each enabled link
  function automatic logic [IDX_W-1:0] img_len(input logic r32, input logic l8, input logic [2:0] n);
    logic [IDX_W-1:0] len;
    len = r32 ? 6'h06 : 6'h04;
    for (int i = 0; i < MAX_LINKS; i++) begin
      if (i < int'(n)) begin
        len = len + (l8 ? 6'h08 : 6'h04);
      end
    end
    return len;
  endfunction

  // Little-endian byte image of one exchange
  function automatic logic [IMG_W-1:0] img_pack(input logic [15:0] w0, input logic [31:0] w1,
                                                input logic [LINKS_W-1:0] lk, input logic r32,
                                                input logic l8);
    logic [IMG_W-1:0] img;
    int               p;
    img       = '0;
    img[15:0] = w0;
    if (r32) begin
      img[47:16] = w1;
    end else begin
      img[31:16] = w1[15:0];
    end
    p = r32 ? 6 : 4;
    for (int k = 0; k < MAX_LINKS; k++) begin
      if (l8) begin
        img[(p + 8 * k) * 8 +: 64] = lk[k * 64 +: 64];
      end else begin
        img[(p + 4 * k) * 8 +: 32] = lk[k * 64 +: 32];
      end
    end
    return img;
  endfunction

  function automatic image_t img_unpack(input logic [IMG_W-1:0] img, input logic r32, input logic l8,
                                        input logic [2:0] n);
    image_t r;
    int     p;
    r    = '0;
    r.w0 = img[15:0];
    r.w1 = r32 ? img[47:16] : {16'h0000, img[31:16]};
    p    = r32 ? 6 : 4;
    for (int k = 0; k < MAX_LINKS; k++) begin
      if (k < int'(n)) begin
        if (l8) begin
          r.lk[k * 64 +: 64] = img[(p + 8 * k) * 8 +: 64];
        end else begin
          r.lk[k * 64 +: 64] = {32'h0000_0000, img[(p + 4 * k) * 8 +: 32]};
        end
      end
    end
    return r;
  endfunction

endpackage

// File: hdl/gw_link_if.sv
// Character link between the scanner and the adapter
`timescale 1ns/1ns
interface gw_link_if;
  logic       m_stb;
  logic       m_sof;
  logic [7:0] m_data;
  logic       m_par;
  logic       s_stb;
  logic       s_sof;
  logic [7:0] s_data;
  logic       s_par;

  modport adapter (input m_stb, input m_sof, input m_data, input m_par,
                   output s_stb, output s_sof, output s_data, output s_par);
  modport scanner (output m_stb, output m_sof, output m_data, output m_par,
                   input s_stb, input s_sof, input s_data, input s_par);
endinterface

// File: hdl/gw_adapter.sv
// Adapter end of the gateway with its reply FIFO
// How it works
// [RL1] Control word is one 16-bit word
// [RL2] Status returns as one 16-bit word
// [RL3] Setpoint is one 16 or 32-bit word
// [RL4] Feedback width matches drive-chosen setpoint width
// [RL5] Each link takes four or eight bytes
// [RL6] Link size comes from the drive
// [RL7] Answer only frames with own address 1-255
// [RL8] Parity bit sent and checked per character
// [RL9] One common character rate on the link
// [RL10] Bus-off blocks all sending and receiving
// [RL11] Configured action sends stored fault values
// [RL12] Hold action keeps last network data
// [RL13] Zero action sends zeros to drive
// [RL14] Clear fault sent only as rising edge
// [RL15] Start sent only after not-stop frame
// [RL16] Timeout declares fault, latches action setting
// [RL17] First valid frame ends fault substitution
`timescale 1ns/1ns
module gw_fifo #(
  parameter int W     = 9,
  parameter int DEPTH = 16
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("FIFO depth must be a power of two of at least 2");
  end

  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wptr;
  logic [AW:0]  rptr;

  assign in_ready  = (wptr[AW-1:0] != rptr[AW-1:0]) || (wptr[AW] == rptr[AW]);
  assign out_valid = wptr != rptr;
  assign out_data  = mem[rptr[AW-1:0]];

  always_ff @(posedge clk) begin
    if (in_valid && in_ready) begin
      mem[wptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wptr <= '0;
      rptr <= '0;
    end else begin
      if (in_valid && in_ready) begin
        wptr <= wptr + 1'b1;
      end
      if (out_valid && out_ready) begin
        rptr <= rptr + 1'b1;
      end
    end
  end
endmodule

module gw_adapter #(
  parameter int N_LINKS    = 4,
  parameter int RATE_DIV   = gw_pkg::CHAR_DIV_CYC,
  parameter int TIMEOUT    = gw_pkg::TIMEOUT_CYC,
  parameter int FIFO_DEPTH = 16
) (
  input  wire logic                        clk,
  input  wire logic                        sys_rst,
  gw_link_if.adapter                       lnk,
  input  wire logic [7:0]                  my_addr,
  input  wire logic                        parity_en,
  input  wire logic                        parity_odd,
  input  wire gw_pkg::fault_action_t       fault_action,
  input  wire logic [15:0]                 flt_ctrl,
  input  wire logic [31:0]                 flt_setpoint,
  input  wire logic [gw_pkg::LINKS_W-1:0]  flt_links,
  input  wire logic                        ref_32,
  input  wire logic                        link_8,
  input  wire logic [15:0]                 drv_status,
  input  wire logic [31:0]                 drv_feedback,
  input  wire logic [gw_pkg::LINKS_W-1:0]  drv_links_in,
  input  wire logic                        bus_off_clear,
  output logic [15:0]                      drv_ctrl,
  output logic [31:0]                      drv_setpoint,
  output logic [gw_pkg::LINKS_W-1:0]       drv_links,
  output logic                             drv_update,
  output logic                             comm_fault,
  output logic                             bus_off
);
  import gw_pkg::*;

  localparam int TW = $clog2(TIMEOUT + 1);

  if (N_LINKS < 0 || N_LINKS > MAX_LINKS || RATE_DIV < 2 || RATE_DIV > 65535 || TIMEOUT < 1)
    begin : g_bad_param
    $error("Adapter parameters out of range");
  end

  logic [15:0]       rate_cnt;
  logic              tick;
  logic              rx_bad;
  logic              rx_act;
  logic              addr_hit;
  logic              rx_perr;
  logic [IDX_W-1:0]  rx_idx;
  logic [IDX_W-1:0]  rx_len;
  logic [IMG_W-1:0]  rx_img;
  logic              frame_ok;
  logic [8:0]        err_cnt;
  logic [TW-1:0]     idle_cnt;
  fault_action_t     act_held;
  image_t            rx_word;
  logic              tx_busy;
  logic [IDX_W-1:0]  tx_idx;
  logic [IDX_W-1:0]  tx_len;
  logic [IMG_W-1:0]  tx_img;
  logic              fifo_in_valid;
  logic              fifo_in_ready;
  logic [8:0]        fifo_in_data;
  logic              fifo_out_valid;
  logic              fifo_out_ready;
  logic [8:0]        fifo_out_data;

  // Character rate divider shared in value with the scanner
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rate_cnt <= '0;
      tick     <= 1'b0;
    end else if (rate_cnt == 16'(RATE_DIV - 1)) begin // RL9
      rate_cnt <= '0;
      tick     <= 1'b1;
    end else begin
      rate_cnt <= rate_cnt + 16'h0001;
      tick     <= 1'b0;
    end
  end

  assign rx_bad = parity_en && (par_bit(lnk.m_data, parity_odd) != lnk.m_par); // RL8

  // Frame receiver
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_act   <= 1'b0;
      addr_hit <= 1'b0;
      rx_perr  <= 1'b0;
      rx_idx   <= '0;
      rx_len   <= '0;
      rx_img   <= '0;
      frame_ok <= 1'b0;
    end else begin
      frame_ok <= 1'b0;
      if (lnk.m_stb && !bus_off) begin // RL10
        if (lnk.m_sof) begin
          rx_act   <= 1'b1;
          rx_idx   <= '0;
          addr_hit <= (lnk.m_data == my_addr) && (my_addr >= ADDR_MIN); // RL7
          rx_perr  <= rx_bad;
          rx_len   <= img_len(ref_32, link_8, 3'(N_LINKS)); // RL5 RL6
        end else if (rx_act) begin
          rx_img[rx_idx * 8 +: 8] <= lnk.m_data;
          rx_idx                  <= rx_idx + 6'h01;
          rx_perr                 <= rx_perr | rx_bad;
          if (rx_idx == rx_len - 6'h01) begin
            rx_act   <= 1'b0;
            frame_ok <= addr_hit && !rx_perr && !rx_bad; // RL7 RL8
          end
        end
      end
    end
  end

  // Error counter and bus-off
  always_ff @(posedge clk) begin
    if (sys_rst || bus_off_clear) begin
      err_cnt <= '0;
      bus_off <= 1'b0;
    end else begin
      if (err_cnt >= ERR_LIMIT) begin
        bus_off <= 1'b1; // RL10
      end else if (lnk.m_stb && rx_bad) begin
        err_cnt <= err_cnt + ERR_INC;
      end else if (frame_ok && err_cnt != 9'h000) begin
        err_cnt <= err_cnt - ERR_DEC;
      end
    end
  end

  // Communication loss supervision
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      idle_cnt   <= '0;
      comm_fault <= 1'b0;
      act_held   <= FA_ZERO;
    end else if (frame_ok) begin
      idle_cnt   <= '0;
      comm_fault <= 1'b0; // RL17
    end else if (!comm_fault) begin
      if (idle_cnt == TW'(TIMEOUT)) begin
        comm_fault <= 1'b1; // RL16
        act_held   <= fault_action; // RL16
      end else begin
        idle_cnt <= idle_cnt + 1'b1;
      end
    end
  end

  assign rx_word = img_unpack(rx_img, ref_32, link_8, 3'(N_LINKS)); // RL1 RL3

  // Data toward the drive
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      drv_ctrl     <= '0;
      drv_setpoint <= '0;
      drv_links    <= '0;
      drv_update   <= 1'b0;
    end else begin
      drv_update <= frame_ok;
      if (frame_ok) begin
        drv_ctrl     <= rx_word.w0;
        drv_setpoint <= rx_word.w1;
        drv_links    <= rx_word.lk;
      end else if (comm_fault) begin
        case (act_held)
          FA_CONFIG: begin
            drv_ctrl     <= flt_ctrl; // RL11
            drv_setpoint <= flt_setpoint;
            drv_links    <= flt_links;
          end
          FA_ZERO: begin
            drv_ctrl     <= '0; // RL13
            drv_setpoint <= '0;
            drv_links    <= '0;
          end
          default: begin
            drv_ctrl <= drv_ctrl; // RL12
          end
        endcase
      end
    end
  end

  // Reply builder pushes status, feedback and links into the FIFO
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_busy <= 1'b0;
      tx_idx  <= '0;
      tx_len  <= '0;
      tx_img  <= '0;
    end else if (bus_off) begin
      tx_busy <= 1'b0; // RL10
    end else if (frame_ok) begin
      tx_busy <= 1'b1;
      tx_idx  <= '0;
      tx_len  <= img_len(ref_32, link_8, 3'(N_LINKS)); // RL5 RL6
      tx_img  <= img_pack(drv_status, drv_feedback, drv_links_in, ref_32, link_8); // RL2 RL4
    end else if (fifo_in_valid && fifo_in_ready) begin
      tx_idx <= tx_idx + 6'h01;
      if (tx_idx == tx_len - 6'h01) begin
        tx_busy <= 1'b0;
      end
    end
  end

  assign fifo_in_valid  = tx_busy && !bus_off;
  assign fifo_in_data   = {tx_idx == '0, tx_img[tx_idx * 8 +: 8]};
  assign fifo_out_ready = tick || bus_off;

  gw_fifo #(.W(9), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  // Reply characters leave one per character tick
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lnk.s_stb  <= 1'b0;
      lnk.s_sof  <= 1'b0;
      lnk.s_data <= '0;
      lnk.s_par  <= 1'b0;
    end else begin
      lnk.s_stb <= fifo_out_valid && tick && !bus_off; // RL9 RL10
      if (fifo_out_valid && tick) begin
        lnk.s_sof  <= fifo_out_data[8];
        lnk.s_data <= fifo_out_data[7:0];
        lnk.s_par  <= parity_en ? par_bit(fifo_out_data[7:0], parity_odd) : 1'b0; // RL8
      end
    end
  end
endmodule

// File: hdl/gw_scanner.sv
// Scanner end of the gateway: sends output images, collects replies
`timescale 1ns/1ns
module gw_scanner #(
  parameter int N_LINKS  = 4,
  parameter int RATE_DIV = gw_pkg::CHAR_DIV_CYC,
  parameter int RSP_WAIT = gw_pkg::RSP_WAIT_CYC
) (
  input  wire logic                        clk,
  input  wire logic                        sys_rst,
  gw_link_if.scanner                       lnk,
  input  wire logic [7:0]                  target_addr,
  input  wire logic                        parity_en,
  input  wire logic                        parity_odd,
  input  wire logic                        ref_32,
  input  wire logic                        link_8,
  input  wire logic [15:0]                 cmd_ctrl,
  input  wire logic [31:0]                 cmd_setpoint,
  input  wire logic [gw_pkg::LINKS_W-1:0]  cmd_links,
  input  wire logic                        clear_fault,
  input  wire logic                        send,
  output logic                             busy,
  output logic                             rsp_valid,
  output logic                             rsp_error,
  output logic [15:0]                      rsp_status,
  output logic [31:0]                      rsp_feedback,
  output logic [gw_pkg::LINKS_W-1:0]       rsp_links
);
  import gw_pkg::*;

  localparam int WW = $clog2(RSP_WAIT + 1);

  if (N_LINKS < 0 || N_LINKS > MAX_LINKS || RATE_DIV < 2 || RATE_DIV > 65535 || RSP_WAIT < 1)
    begin : g_bad_param
    $error("Scanner parameters out of range");
  end

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SEND = 2'b01,
    ST_WAIT = 2'b10
  } state_t;

  state_t            state;
  logic [15:0]       rate_cnt;
  logic              tick;
  logic              clr_pend;
  logic              last_clear;
  logic              not_stop_seen;
  logic [15:0]       next_ctrl;
  logic              take;
  logic [IDX_W-1:0]  tx_idx;
  logic [IDX_W-1:0]  tx_len;
  logic [IMG_W-1:0]  tx_img;
  logic [7:0]        tx_byte;
  logic [WW-1:0]     wait_cnt;
  logic              rx_act;
  logic              rx_perr;
  logic              rx_bad;
  logic [IDX_W-1:0]  rx_idx;
  logic [IDX_W-1:0]  rx_pos;
  logic [IDX_W-1:0]  rsp_len;
  logic [IMG_W-1:0]  rx_img;
  logic [IMG_W-1:0]  rsp_img;
  image_t            rsp_word;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rate_cnt <= '0;
      tick     <= 1'b0;
    end else if (rate_cnt == 16'(RATE_DIV - 1)) begin // RL9
      rate_cnt <= '0;
      tick     <= 1'b1;
    end else begin
      rate_cnt <= rate_cnt + 16'h0001;
      tick     <= 1'b0;
    end
  end

  assign take = send && (state == ST_IDLE);

  // Control word shaping for edge-triggered clear and guarded start
  always_comb begin
    next_ctrl           = cmd_ctrl; // RL1
    next_ctrl[CW_CLEAR] = clr_pend && !last_clear; // RL14
    next_ctrl[CW_START] = cmd_ctrl[CW_START] && not_stop_seen; // RL15
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      clr_pend      <= 1'b0;
      last_clear    <= 1'b0;
      not_stop_seen <= 1'b0;
    end else begin
      clr_pend <= clear_fault || (clr_pend && !(take && next_ctrl[CW_CLEAR]));
      if (take) begin
        last_clear    <= next_ctrl[CW_CLEAR];
        not_stop_seen <= !(next_ctrl[CW_STOP] || next_ctrl[CW_CLSTOP] || next_ctrl[CW_COAST]); // RL15
      end
    end
  end

  assign tx_byte = (tx_idx == '0) ? target_addr : tx_img[(tx_idx - 6'h01) * 8 +: 8];
  assign rx_bad  = parity_en && (par_bit(lnk.s_data, parity_odd) != lnk.s_par); // RL8
  assign rx_pos  = lnk.s_sof ? '0 : rx_idx;
  assign rsp_len = img_len(ref_32, link_8, 3'(N_LINKS)); // RL5

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state      <= ST_IDLE;
      busy       <= 1'b0;
      tx_idx     <= '0;
      tx_len     <= '0;
      tx_img     <= '0;
      wait_cnt   <= '0;
      lnk.m_stb  <= 1'b0;
      lnk.m_sof  <= 1'b0;
      lnk.m_data <= '0;
      lnk.m_par  <= 1'b0;
    end else begin
      lnk.m_stb <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (take) begin
            state  <= ST_SEND;
            busy   <= 1'b1;
            tx_idx <= '0;
            tx_len <= rsp_len + 6'h01;
            tx_img <= img_pack(next_ctrl, cmd_setpoint, cmd_links, ref_32, link_8); // RL3
          end
        end
        ST_SEND: begin
          if (tick) begin // RL9
            lnk.m_stb  <= 1'b1;
            lnk.m_sof  <= tx_idx == '0;
            lnk.m_data <= tx_byte; // RL7
            lnk.m_par  <= parity_en ? par_bit(tx_byte, parity_odd) : 1'b0; // RL8
            tx_idx     <= tx_idx + 6'h01;
            if (tx_idx == tx_len - 6'h01) begin
              state    <= ST_WAIT;
              wait_cnt <= '0;
            end
          end
        end
        ST_WAIT: begin
          if ((lnk.s_stb && (lnk.s_sof || rx_act) && rx_pos == rsp_len - 6'h01) || wait_cnt == WW'(RSP_WAIT)) begin
            state <= ST_IDLE;
            busy  <= 1'b0;
          end else begin
            wait_cnt <= wait_cnt + 1'b1;
          end
        end
        default: begin
          state <= ST_IDLE;
          busy  <= 1'b0;
        end
      endcase
    end
  end

  // Reply image with the final byte merged at its own position
  always_comb begin
    rsp_img                  = rx_img;
    rsp_img[rx_pos * 8 +: 8] = lnk.s_data;
  end

  assign rsp_word = img_unpack(rsp_img, ref_32, link_8, 3'(N_LINKS));

  // Reply collector
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_act       <= 1'b0;
      rx_perr      <= 1'b0;
      rx_idx       <= '0;
      rx_img       <= '0;
      rsp_valid    <= 1'b0;
      rsp_error    <= 1'b0;
      rsp_status   <= '0;
      rsp_feedback <= '0;
      rsp_links    <= '0;
    end else begin
      rsp_valid <= 1'b0;
      rsp_error <= 1'b0;
      if (state != ST_WAIT) begin
        rx_act <= 1'b0;
      end else if (lnk.s_stb && (lnk.s_sof || rx_act)) begin
        rx_img[rx_pos * 8 +: 8] <= lnk.s_data;
        rx_idx                  <= rx_pos + 6'h01;
        rx_act                  <= 1'b1;
        rx_perr                 <= (lnk.s_sof ? 1'b0 : rx_perr) | rx_bad;
        if (rx_pos == rsp_len - 6'h01) begin
          rx_act    <= 1'b0;
          rsp_valid <= 1'b1;
          rsp_error <= (lnk.s_sof ? 1'b0 : rx_perr) | rx_bad;
        end
      end else if (wait_cnt == WW'(RSP_WAIT)) begin
        rsp_error <= 1'b1;
      end
      if (state == ST_WAIT && lnk.s_stb && (lnk.s_sof || rx_act) && rx_pos == rsp_len - 6'h01) begin
        rsp_status   <= rsp_word.w0; // RL2
        rsp_feedback <= rsp_word.w1; // RL4
        rsp_links    <= rsp_word.lk;
      end
    end
  end
endmodule

// File: tb/gw_link_props.sv
// Checker of the character link between the two gateway ends
`timescale 1ns/1ns
module gw_link_props #(
  parameter int F_LEN = 11,
  parameter int R_LEN = 10
) (
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       m_stb,
  input wire logic       m_sof,
  input wire logic [7:0] m_data,
  input wire logic       m_par,
  input wire logic       s_stb,
  input wire logic       s_sof,
  input wire logic [7:0] s_data,
  input wire logic       s_par
);
  logic [7:0] mcnt;
  logic [7:0] scnt;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Characters seen since the last frame start
  always_ff @(posedge clk) begin
    if (sys_rst) mcnt <= 8'h00;
    else if (m_stb) mcnt <= m_sof ? 8'h01 : mcnt + 8'h01;
  end
  always_ff @(posedge clk) begin
    if (sys_rst) scnt <= 8'h00;
    else if (s_stb) scnt <= s_sof ? 8'h01 : scnt + 8'h01;
  end
  a_m_par_odd: assert property (m_stb |-> ^{m_data, m_par}) else $error("bad parity on frame");
  a_s_par_odd: assert property (s_stb |-> ^{s_data, s_par}) else $error("bad parity on reply");
  a_m_char_gap: assert property (m_stb |=> !m_stb [*3]) else $error("frame chars too close");
  a_s_char_gap: assert property (s_stb |=> !s_stb [*3]) else $error("reply chars too close");
  a_m_frame_len: assert property (m_stb && m_sof |-> mcnt == 0 || mcnt == F_LEN) else $error("frame length");
  a_s_frame_len: assert property (s_stb && s_sof |-> scnt == 0 || scnt == R_LEN) else $error("reply length");
  a_m_no_extra: assert property (m_stb && !m_sof |-> mcnt != 0 && mcnt < F_LEN) else $error("frame overrun");
  a_m_addr_first: assert property (m_stb && m_sof |-> m_data != 8'h00) else $error("frame address zero");
  a_s_after_frame: assert property (s_stb && s_sof |-> mcnt == F_LEN && !m_stb) else $error("early reply");
  a_s_first_sof: assert property (s_stb && scnt == 0 |-> s_sof) else $error("reply without start");
endmodule

// File: tb/tb.sv
// Testbench joining scanner and adapter ends of the gateway
`timescale 1ns/1ns
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_fail++; \
  $display("[ERR] %0t got %0h exp %0h", $time, (g), (e)); end end
module tb;
  import gw_pkg::*;
  localparam int TMO = 2000;
  logic               clk, sys_rst, send, clear_fault, busy, rv, re, du, cf, bo, pe, po, po_a, r32, l8, boc;
  logic [7:0]         tgt, addr;
  fault_action_t      fa;
  logic [15:0]        cc, st, rst16, dc, fc;
  logic [31:0]        sp, fb, rfb, dsp, fsp;
  logic [LINKS_W-1:0] lk, li, rlk, dlk, flk;
  int                 n_fail, checked;
  gw_link_if lnk ();
  gw_scanner #(.N_LINKS(1), .RATE_DIV(4), .RSP_WAIT(1500)) u_gw_scanner (.clk(clk), .sys_rst(sys_rst),
    .lnk(lnk), .target_addr(tgt), .parity_en(pe), .parity_odd(po), .ref_32(r32), .link_8(l8),
    .cmd_ctrl(cc), .cmd_setpoint(sp), .cmd_links(lk), .clear_fault(clear_fault), .send(send), .busy(busy),
    .rsp_valid(rv), .rsp_error(re), .rsp_status(rst16), .rsp_feedback(rfb), .rsp_links(rlk));
  gw_adapter #(.N_LINKS(1), .RATE_DIV(4), .TIMEOUT(TMO), .FIFO_DEPTH(16)) u_gw_adapter (.clk(clk),
    .sys_rst(sys_rst), .lnk(lnk), .my_addr(addr), .parity_en(pe), .parity_odd(po_a), .fault_action(fa),
    .flt_ctrl(fc), .flt_setpoint(fsp), .flt_links(flk), .ref_32(r32),
    .link_8(l8), .drv_status(st), .drv_feedback(fb), .drv_links_in(li), .bus_off_clear(boc),
    .drv_ctrl(dc), .drv_setpoint(dsp), .drv_links(dlk), .drv_update(du), .comm_fault(cf), .bus_off(bo));
  gw_link_props #(.F_LEN(11), .R_LEN(10)) u_gw_link_props (.clk(clk), .sys_rst(sys_rst),
    .m_stb(lnk.m_stb), .m_sof(lnk.m_sof), .m_data(lnk.m_data), .m_par(lnk.m_par),
    .s_stb(lnk.s_stb), .s_sof(lnk.s_sof), .s_data(lnk.s_data), .s_par(lnk.s_par));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic stop_test;
    if (n_fail == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // One exchange; ex is the control word the drive should see
  task automatic xfer(input logic [15:0] c, input logic [15:0] ex, input logic ok);
    int   i;
    logic seen;
    cc = c;
    st = ~c;
    fb = {c, ~c};
    li = {16{c}};
    sp = {~c, c};
    lk = {16{c}};
    seen = 1'b0;
    send = 1'b1;
    @(negedge clk);
    send = 1'b0;
    `CHK(busy, 1'b1)
    for (i = 0; i < 3000; i++) begin
      @(negedge clk);
      if (du === 1'b1) begin
        seen = 1'b1;
        `CHK(dc, ex)
        `CHK(dsp, sp)
        `CHK(dlk[63:0], {32'h0, lk[31:0]})
      end
      if (rv === 1'b1 || re === 1'b1) break;
    end
    if (i == 3000) begin
      n_fail++;
      stop_test();
    end
    `CHK(seen, ok)
    `CHK(rv, ok)
    `CHK(busy, 1'b0)
    `CHK(re, ~ok)
    if (ok) begin
      `CHK(rst16, st)
      `CHK(rfb, fb)
      `CHK(rlk[31:0], li[31:0])
    end
  endtask
  // Let the link go quiet, then check substitution for one action
  task automatic fault(input fault_action_t a, input logic [15:0] last);
    int          n;
    logic [15:0] ec;
    fa = a;
    n = 0;
    while (cf !== 1'b1 && n < TMO + 10) begin
      @(negedge clk);
      n++;
    end
    `CHK(n > TMO - 300 && n <= TMO, 1'b1)
    if (n >= TMO + 10) stop_test();
    ec = (a == FA_CONFIG) ? fc : (a == FA_HOLD) ? last : 16'h0000;
    @(negedge clk);
    fa = fault_action_t'(a ^ 2'b11);
    repeat (2) @(negedge clk);
    `CHK(dc, ec)
    `CHK(dsp, (a == FA_CONFIG) ? fsp : (a == FA_HOLD) ? {~last, last} : 32'h0)
    `CHK(dlk[63:0], (a == FA_CONFIG) ? flk[63:0] : (a == FA_HOLD) ? {32'h0, {2{last}}} : 64'h0)
  endtask
  initial begin
    n_fail = 0;
    checked = 0;
    sys_rst = 1'b1;
    send = 1'b0;
    clear_fault = 1'b0;
    tgt = 8'h2A;
    fa = FA_HOLD;
    cc = 16'h0000;
    sp = 32'h0;
    lk = '0;
    st = 16'h0000;
    fb = 32'h0;
    li = '0;
    pe = 1'b1;
    po = 1'b1;
    po_a = 1'b1;
    r32 = 1'b1;
    l8 = 1'b0;
    boc = 1'b0;
    addr = 8'h2A;
    fc = 16'hA5C3;
    fsp = 32'h1234_5678;
    flk = '1;
    repeat (6) @(negedge clk);
    sys_rst = 1'b0;
    xfer(16'h0002, 16'h0000, 1'b1);
    xfer(16'h0002, 16'h0002, 1'b1);
    xfer(16'h0103, 16'h0103, 1'b1);
    xfer(16'h0002, 16'h0000, 1'b1);
    clear_fault = 1'b1;
    @(negedge clk);
    clear_fault = 1'b0;
    xfer(16'h0000, 16'h0008, 1'b1);
    xfer(16'h0000, 16'h0000, 1'b1);
    tgt = 8'h2B;
    xfer(16'h0010, 16'h0010, 1'b0);
    tgt = 8'h2A;
    for (int k = 0; k < 3; k++) begin
      xfer(16'h4C50 ^ (k << 4), 16'h4C50 ^ (k << 4), 1'b1);
      fault(fault_action_t'(k), 16'h4C50 ^ (k << 4));
      xfer(16'h2460, 16'h2460, 1'b1);
      `CHK(cf, 1'b0)
    end
    po_a = 1'b0;
    repeat (3) xfer(16'h0000, 16'h0000, 1'b0);
    po_a = 1'b1;
    `CHK(bo, 1'b1)
    xfer(16'h0000, 16'h0000, 1'b0);
    boc = 1'b1;
    @(negedge clk);
    boc = 1'b0;
    xfer(16'h2460, 16'h2460, 1'b1);
    `CHK(cf, 1'b0)
    `CHK(bo, 1'b0)
    stop_test();
  end
endmodule
